//--- analog_ctrl_pkg.sv
`default_nettype none

package analog_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] COMPARATOR_ONE_CONTROL_ADDR = 8'h9f; // Comparator control register address.
	localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hd1; // Reference control register address.
	localparam logic [7:0] COMPARATOR_ONE_CONTROL_RESET = 8'h00; // Comparator control reset value.
	localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00; // Reference control reset value.

	// ----------------------------------------------------------------
	// Comparator control field positions
	// ----------------------------------------------------------------
	localparam int CMP_ENABLE_BIT = 7; // Comparator enable.
	localparam int CMP_OUTPUT_STATE_BIT = 6; // Live output state, read only.
	localparam int CMP_RISE_FLAG_BIT = 5; // Sticky rising-edge flag.
	localparam int CMP_FALL_FLAG_BIT = 4; // Sticky falling-edge flag.
	localparam int CMP_POS_HYST_LSB = 2; // Positive hysteresis field, bits 3-2.
	localparam int CMP_NEG_HYST_LSB = 0; // Negative hysteresis field, bits 1-0.

	// ----------------------------------------------------------------
	// Reference control field positions
	// ----------------------------------------------------------------
	localparam int TEMP_SENSOR_ENABLE_BIT = 2; // Temperature sensor enable.
	localparam int ANALOG_BIAS_ENABLE_BIT = 1; // Converter bias enable.
	localparam int REF_BUFFER_ENABLE_BIT = 0; // Bandgap and buffer enable.
	localparam logic [7:0] REFERENCE_WRITE_MASK = 8'h07; // Bits 7-3 are unused.

	// ----------------------------------------------------------------
	// Hysteresis codes and timing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HYST_OFF = 2'b00,
		HYST_SMALL = 2'b01,
		HYST_MEDIUM = 2'b10,
		HYST_LARGE = 2'b11
	} hyst_level_e;

	localparam int CLK_MHZ = 250; // System clock rate in MHz.
	localparam int CMP_POWERUP_US = 20; // Comparator settling time in microseconds.
	localparam int CMP_POWERUP_CYCLES = CMP_POWERUP_US * CLK_MHZ; // 5000 cycles.

endpackage

`default_nettype wire

//--- cmp_edge_if.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Carries the sampled comparator state from the edge detector.
// --------------------------------------------------------------------
interface cmp_edge_if;
	logic enable; // Comparator enable from the register.
	logic level; // Synchronised, enable-gated comparator output.
	logic rise_pulse; // One-cycle pulse on a rising transition.
	logic fall_pulse; // One-cycle pulse on a falling transition.
	logic settled; // High once the power-up interval has elapsed.

	modport detector (input enable, output level, output rise_pulse, output fall_pulse, output settled);
	modport consumer (output enable, input level, input rise_pulse, input fall_pulse, input settled);
endinterface

`default_nettype wire

//--- cmp_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Synchroniser, edge detector and power-up timer for the comparator.
// --------------------------------------------------------------------
module cmp_edge_detect #(
	parameter int POWERUP_CYCLES = analog_ctrl_pkg::CMP_POWERUP_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cmp_raw,
	cmp_edge_if.detector edge_bus
);

	// Counter width follows the settling count, so a faster clock with a longer count cannot wrap early.
	localparam int CNT_W = $clog2(POWERUP_CYCLES + 1);

	logic sync1_reg; // First synchroniser stage, read only by the second.
	logic sync2_reg; // Second synchroniser stage.
	logic level_reg; // Gated level, used for edge comparison.
	logic rise_reg; // Registered rising pulse.
	logic fall_reg; // Registered falling pulse.
	logic [CNT_W-1:0] pwr_cnt_reg; // Counts the power-up interval.

	// Two flops bring the analog output into the clock domain.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= cmp_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// A disabled comparator reads low and makes no edges, so no event
	// is raised while it is shut down.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			level_reg <= edge_bus.enable & sync2_reg;
			rise_reg <= edge_bus.enable & sync2_reg & ~level_reg;
			fall_reg <= edge_bus.enable & ~sync2_reg & level_reg;
		end
	end

	// Power-up counter restarts whenever the comparator is disabled.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_cnt_reg <= '0;
		end else if (!edge_bus.enable) begin
			pwr_cnt_reg <= '0;
		end else if (pwr_cnt_reg != CNT_W'(POWERUP_CYCLES)) begin
			pwr_cnt_reg <= pwr_cnt_reg + CNT_W'(1);
		end
	end

	assign edge_bus.level = level_reg;
	assign edge_bus.rise_pulse = rise_reg;
	assign edge_bus.fall_pulse = fall_reg;
	assign edge_bus.settled = (pwr_cnt_reg == CNT_W'(POWERUP_CYCLES));

	a_no_edge_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
		!edge_bus.enable |=> !rise_reg && !fall_reg) else $error("edge while disabled");

endmodule // cmp_edge_detect

`default_nettype wire

//--- analog_control_registers.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Comparator register at 0x9F, resets zero.
// - Bits 3-2 select positive hysteresis level.
// - Bits 1-0 select negative hysteresis level.
// - Reference register at 0xD1, upper bits zero.
// - Bias bit powers converter bias circuitry.
// - Buffer bit powers bandgap and buffer.
// - Buffer off leaves reference output floating.
// - Bit 2 switches temperature sensor.
// - Disabled sensor output floats, samples invalid.
// - Sensor routes to highest converter input.
// - Transitions set rising or falling flags.
// - Edge flags stick until CPU clears.
// - Disabled comparator drives low, no events.
// - Behaves like first comparator, no reset.
module analog_control_registers #(
	parameter int POWERUP_CYCLES = analog_ctrl_pkg::CMP_POWERUP_CYCLES,
	parameter int ADC_MUX_INPUTS = 9
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic cmp_raw,
	output logic cmp_pin_level,
	output logic cmp_rise_event,
	output logic cmp_fall_event,
	output logic cmp_settled,
	output logic cmp_power_on,
	output logic [1:0] cmp_pos_hyst_sel,
	output logic [1:0] cmp_neg_hyst_sel,
	output logic analog_bias_enable,
	output logic converters_allowed,
	output logic bandgap_enable,
	output logic ref_buffer_enable,
	output logic ref_out_oe_n,
	output logic temp_sensor_enable,
	output logic temp_out_oe_n,
	output logic temp_sample_valid,
	output logic [$clog2(ADC_MUX_INPUTS)-1:0] temp_mux_index
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic cmp_enable_reg; // Comparator enable.
	logic cmp_rise_flag_reg; // Sticky rising flag.
	logic cmp_fall_flag_reg; // Sticky falling flag.
	logic [1:0] pos_hyst_reg; // Positive hysteresis code.
	logic [1:0] neg_hyst_reg; // Negative hysteresis code.
	logic [2:0] ref_ctrl_reg; // Temp sensor, bias, buffer enables.
	logic wr_cmp; // Write strobe to comparator register.
	logic wr_ref; // Write strobe to reference register.

	cmp_edge_if edge_bus();

	// ----------------------------------------------------------------
	// Edge detection and settling timer
	// ----------------------------------------------------------------
	cmp_edge_detect #(
		.POWERUP_CYCLES(POWERUP_CYCLES)
	) u_edge (
		.mclk(mclk),
		.rst_n(rst_n),
		.cmp_raw(cmp_raw),
		.edge_bus(edge_bus)
	);

	assign edge_bus.enable = cmp_enable_reg;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign wr_cmp = sfr_wr && (sfr_addr == analog_ctrl_pkg::COMPARATOR_ONE_CONTROL_ADDR);
	assign wr_ref = sfr_wr && (sfr_addr == analog_ctrl_pkg::REFERENCE_CONTROL_ADDR);

	// Enable and hysteresis fields; bit 6 of the write is dropped because
	// the output state is a live reading, not storage.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_enable_reg <= 1'b0;
			pos_hyst_reg <= 2'b00;
			neg_hyst_reg <= 2'b00;
		end else if (wr_cmp) begin
			cmp_enable_reg <= sfr_wdata[analog_ctrl_pkg::CMP_ENABLE_BIT];
			pos_hyst_reg <= sfr_wdata[analog_ctrl_pkg::CMP_POS_HYST_LSB +: 2];
			neg_hyst_reg <= sfr_wdata[analog_ctrl_pkg::CMP_NEG_HYST_LSB +: 2];
		end
	end

	// Sticky flags: a hardware edge in the same cycle as a software clear
	// wins, so no transition is lost. Software may also set a flag.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_rise_flag_reg <= 1'b0;
			cmp_fall_flag_reg <= 1'b0;
		end else begin
			if (edge_bus.rise_pulse) begin
				cmp_rise_flag_reg <= 1'b1;
			end else if (wr_cmp) begin
				cmp_rise_flag_reg <= sfr_wdata[analog_ctrl_pkg::CMP_RISE_FLAG_BIT];
			end
			if (edge_bus.fall_pulse) begin
				cmp_fall_flag_reg <= 1'b1;
			end else if (wr_cmp) begin
				cmp_fall_flag_reg <= sfr_wdata[analog_ctrl_pkg::CMP_FALL_FLAG_BIT];
			end
		end
	end

	// Reference control keeps only its three live bits.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ref_ctrl_reg <= 3'h0;
		end else if (wr_ref) begin
			ref_ctrl_reg <= sfr_wdata[2:0] & analog_ctrl_pkg::REFERENCE_WRITE_MASK[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Read data, registered one cycle after the read strobe
	// ----------------------------------------------------------------
	// Bit 6 is taken from the live gated level, never from storage, so a
	// read always shows the comparator as it stands now.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
		end else if (sfr_rd && sfr_addr == analog_ctrl_pkg::COMPARATOR_ONE_CONTROL_ADDR) begin
			sfr_rdata <= {cmp_enable_reg, edge_bus.level, cmp_rise_flag_reg, cmp_fall_flag_reg,
				pos_hyst_reg, neg_hyst_reg};
			sfr_hit <= 1'b1;
		end else if (sfr_rd && sfr_addr == analog_ctrl_pkg::REFERENCE_CONTROL_ADDR) begin
			sfr_rdata <= {5'h00, ref_ctrl_reg};
			sfr_hit <= 1'b1;
		end else begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Analog controls
	// ----------------------------------------------------------------
	// The level driven toward a pin is forced low while disabled, inside
	// the detector. This comparator has no reset-source output.
	assign cmp_pin_level = edge_bus.level;
	assign cmp_rise_event = edge_bus.rise_pulse;
	assign cmp_fall_event = edge_bus.fall_pulse;
	assign cmp_settled = edge_bus.settled;
	assign cmp_power_on = cmp_enable_reg;
	assign cmp_pos_hyst_sel = pos_hyst_reg;
	assign cmp_neg_hyst_sel = neg_hyst_reg;

	assign analog_bias_enable = ref_ctrl_reg[analog_ctrl_pkg::ANALOG_BIAS_ENABLE_BIT];
	assign converters_allowed = ref_ctrl_reg[analog_ctrl_pkg::ANALOG_BIAS_ENABLE_BIT];
	assign bandgap_enable = ref_ctrl_reg[analog_ctrl_pkg::REF_BUFFER_ENABLE_BIT];
	assign ref_buffer_enable = ref_ctrl_reg[analog_ctrl_pkg::REF_BUFFER_ENABLE_BIT];
	// Active-low enable: high means the buffer floats for an external source.
	assign ref_out_oe_n = ~ref_ctrl_reg[analog_ctrl_pkg::REF_BUFFER_ENABLE_BIT];
	assign temp_sensor_enable = ref_ctrl_reg[analog_ctrl_pkg::TEMP_SENSOR_ENABLE_BIT];
	assign temp_out_oe_n = ~ref_ctrl_reg[analog_ctrl_pkg::TEMP_SENSOR_ENABLE_BIT];
	assign temp_sample_valid = ref_ctrl_reg[analog_ctrl_pkg::TEMP_SENSOR_ENABLE_BIT];
	// The sensor always takes the last converter input; the mux size is a
	// parameter because other parts of the family carry fewer inputs.
	assign temp_mux_index = ($clog2(ADC_MUX_INPUTS))'(ADC_MUX_INPUTS - 1);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// A clear is a write of zero to the flag bit in a cycle with no edge;
	// an edge in the same cycle must win, so it is left out of the clear.
	sequence s_clear_write;
		wr_cmp && !sfr_wdata[analog_ctrl_pkg::CMP_RISE_FLAG_BIT] && !edge_bus.rise_pulse;
	endsequence

	sequence s_fall_clear_write;
		wr_cmp && !sfr_wdata[analog_ctrl_pkg::CMP_FALL_FLAG_BIT] && !edge_bus.fall_pulse;
	endsequence

	a_rise_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		edge_bus.rise_pulse |=> cmp_rise_flag_reg) else $error("rise flag not set");
	a_fall_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		edge_bus.fall_pulse |=> cmp_fall_flag_reg) else $error("fall flag not set");
	a_flag_sticks: assert property (@(posedge mclk) disable iff (!rst_n)
		cmp_rise_flag_reg && !wr_cmp |=> cmp_rise_flag_reg) else $error("rise flag lost");
	a_clear_works: assert property (@(posedge mclk) disable iff (!rst_n)
		s_clear_write |=> !cmp_rise_flag_reg) else $error("rise flag not cleared");
	a_fall_sticks: assert property (@(posedge mclk) disable iff (!rst_n)
		cmp_fall_flag_reg && !wr_cmp |=> cmp_fall_flag_reg) else $error("fall flag lost");
	a_fall_clears: assert property (@(posedge mclk) disable iff (!rst_n)
		s_fall_clear_write |=> !cmp_fall_flag_reg) else $error("fall flag not cleared");
	a_pos_hyst_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_cmp |=> cmp_pos_hyst_sel == $past(sfr_wdata[3:2])) else $error("pos hyst wrong");
	a_neg_hyst_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_cmp |=> cmp_neg_hyst_sel == $past(sfr_wdata[1:0])) else $error("neg hyst wrong");
	a_ref_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		sfr_rd && sfr_addr == analog_ctrl_pkg::REFERENCE_CONTROL_ADDR |=> sfr_rdata[7:3] == 5'h00)
		else $error("ref upper bits nonzero");
	a_buffer_float: assert property (@(posedge mclk) disable iff (!rst_n)
		ref_out_oe_n == !bandgap_enable) else $error("buffer enable mismatch");
	a_bias_gates_conv: assert property (@(posedge mclk) disable iff (!rst_n)
		converters_allowed == analog_bias_enable) else $error("converters allowed without bias");
	a_sensor_float: assert property (@(posedge mclk) disable iff (!rst_n)
		temp_out_oe_n == !temp_sensor_enable) else $error("sensor output enable mismatch");
	a_pin_low_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!cmp_enable_reg |=> !cmp_pin_level) else $error("pin not low when disabled");
	a_out_bit_ro: assert property (@(posedge mclk) disable iff (!rst_n)
		sfr_rd && sfr_addr == analog_ctrl_pkg::COMPARATOR_ONE_CONTROL_ADDR |=>
		sfr_rdata[analog_ctrl_pkg::CMP_OUTPUT_STATE_BIT] == $past(edge_bus.level))
		else $error("output bit not live");
	a_enable_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_cmp |=> cmp_enable_reg == $past(sfr_wdata[7])) else $error("enable write wrong");

endmodule // analog_control_registers

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the comparator and reference registers.
// ----------------------------------------------------------------
module tb_top;
	localparam int PWR = 10; // Short settling count keeps the run brief.
	logic mclk = 1'b0; // System clock, 4 ns period.
	logic rst_n = 1'b0; // Active-low reset, held at start.
	logic [7:0] sfr_addr = 8'h00; // Register address.
	logic [7:0] sfr_wdata = 8'h00; // Write data.
	logic sfr_wr = 1'b0; // Write strobe.
	logic sfr_rd = 1'b0; // Read strobe.
	logic cmp_raw = 1'b0; // Raw comparator output.
	logic [7:0] sfr_rdata; // Registered read data.
	logic sfr_hit; // Mapped read seen.
	logic cmp_pin_level, cmp_rise_event, cmp_fall_event, cmp_settled, cmp_power_on;
	logic [1:0] cmp_pos_hyst_sel; // Positive hysteresis field.
	logic [1:0] cmp_neg_hyst_sel; // Negative hysteresis field.
	logic analog_bias_enable, converters_allowed, bandgap_enable, ref_buffer_enable, ref_out_oe_n;
	logic temp_sensor_enable, temp_out_oe_n, temp_sample_valid;
	logic [3:0] temp_mux_index; // Sensor input of the converter mux.
	logic [7:0] ref_vec; // Reference outputs gathered for one compare.
	int n_mismatch = 0; // Mismatches seen.
	int tests_run = 0; // Comparisons made.

	assign ref_vec = {temp_sensor_enable, temp_sample_valid, temp_out_oe_n, analog_bias_enable,
		converters_allowed, bandgap_enable, ref_buffer_enable, ref_out_oe_n};

	// Free-running clock.
	always #2 mclk = ~mclk;

	analog_control_registers #(.POWERUP_CYCLES(PWR), .ADC_MUX_INPUTS(9)) analog_control_registers_i (
		.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .cmp_raw(cmp_raw),
		.cmp_pin_level(cmp_pin_level), .cmp_rise_event(cmp_rise_event), .cmp_fall_event(cmp_fall_event),
		.cmp_settled(cmp_settled), .cmp_power_on(cmp_power_on), .cmp_pos_hyst_sel(cmp_pos_hyst_sel),
		.cmp_neg_hyst_sel(cmp_neg_hyst_sel), .analog_bias_enable(analog_bias_enable),
		.converters_allowed(converters_allowed), .bandgap_enable(bandgap_enable),
		.ref_buffer_enable(ref_buffer_enable), .ref_out_oe_n(ref_out_oe_n),
		.temp_sensor_enable(temp_sensor_enable), .temp_out_oe_n(temp_out_oe_n),
		.temp_sample_valid(temp_sample_valid), .temp_mux_index(temp_mux_index));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	// Compares with case equality so an unknown never passes.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One write; strobe rises and falls on falling edges.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask

	// One read; data stands one cycle, so it is taken at the next falling edge.
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge mclk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		check(sfr_rdata, exp, what);
		check({7'h00, sfr_hit}, {7'h00, (a == 8'h9f) || (a == 8'hd1)}, "read hit");
	endtask

	// Bounded wait: 0 settled, 1 rising event, 2 falling event.
	task automatic await(input int sel);
		int i;
		for (i = 0; i < 3 * PWR; i++) begin
			if ((sel == 0 && cmp_settled === 1'b1) || (sel == 1 && cmp_rise_event === 1'b1) ||
				(sel == 2 && cmp_fall_event === 1'b1)) begin
				return;
			end
			@(negedge mclk);
		end
		n_mismatch++;
		$display("[FAIL] %0t wait %0d ran out", $time, sel);
		conclude();
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Values straight after reset.
	task automatic t_reset();
		check(ref_vec, 8'h21, "reference outputs at reset");
		rdchk(8'h9f, 8'h00, "comparator reset");
		rdchk(8'hd1, 8'h00, "reference reset");
		check({4'h0, temp_mux_index}, 8'h08, "sensor mux input");
		$display("test reset done");
	endtask

	// Four reference settings (all on, bias only, sensor only, all off), the unused bits and an unmapped place.
	task automatic t_reference();
		wr(8'hd1, 8'hff);
		rdchk(8'hd1, 8'h07, "upper bits read zero");
		check(ref_vec, 8'hde, "internal reference");
		wr(8'hd1, 8'h02);
		check(ref_vec, 8'h39, "external reference");
		wr(8'hd1, 8'h04);
		check(ref_vec, 8'hc1, "sensor only");
		wr(8'hd1, 8'h00);
		wr(8'ha0, 8'hff);
		check(ref_vec, 8'h21, "all off, stray write ignored");
		rdchk(8'ha0, 8'h00, "unmapped read");
		$display("test reference done");
	endtask

	// All sixteen hysteresis code pairs.
	task automatic t_hyst();
		logic [7:0] v;
		for (int k = 0; k < 16; k++) begin
			v = 8'(k);
			wr(8'h9f, v);
			check({4'h0, cmp_pos_hyst_sel, cmp_neg_hyst_sel}, v, "hysteresis fields");
			rdchk(8'h9f, v, "hysteresis readback");
		end
		$display("test hysteresis done");
	endtask

	// Enable, settle, both edges, sticky flags, clearing.
	task automatic t_edges();
		wr(8'h9f, 8'hc3);
		check({7'h00, cmp_power_on}, 8'h01, "comparator powered");
		check({7'h00, cmp_settled}, 8'h00, "settling just begun");
		rdchk(8'h9f, 8'h83, "output bit not writable");
		await(0);
		cmp_raw = 1'b1;
		await(1);
		check({7'h00, cmp_pin_level}, 8'h01, "level follows high");
		@(negedge mclk);
		check({7'h00, cmp_rise_event}, 8'h00, "rise pulse one cycle");
		rdchk(8'h9f, 8'he3, "rise flag set");
		cmp_raw = 1'b0;
		await(2);
		repeat (4) @(negedge mclk);
		rdchk(8'h9f, 8'hb3, "fall flag set, rise flag held");
		wr(8'h9f, 8'h83);
		rdchk(8'h9f, 8'h83, "flags cleared by write");
		$display("test edges done");
	endtask

	// A disabled comparator shows no level and no events.
	task automatic t_disable();
		logic seen;
		seen = 1'b0;
		wr(8'h9f, 8'h00);
		check({7'h00, cmp_power_on}, 8'h00, "comparator powered down");
		cmp_raw = 1'b1;
		repeat (8) begin
			@(negedge mclk);
			seen = seen | cmp_rise_event | cmp_fall_event | cmp_pin_level;
		end
		check({7'h00, seen}, 8'h00, "disabled stays quiet");
		rdchk(8'h9f, 8'h00, "no flags while disabled");
		cmp_raw = 1'b0;
		$display("test disable done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_reference();
		t_hyst();
		t_edges();
		t_disable();
		conclude();
	end
endmodule // tb_top

`default_nettype wire
